// ### hdl/wdg_timer.sv
// Purpose: watchdog timer with two safety levels, APB register access
// Assumes: one pclk domain; each APB write stands for one instruction
// Notes: restart, vector taken and global enable arrive through a command register
//
// Functional notes
// R01 - counter advances on a 128 kHz oscillator rate, independent of pclk rate; here the tick is pclk divided by OSC_DIV
// R02 - counter cleared by restart, by disabling, and by any device reset
// R03 - expiry with reset action enabled resets the device
// R04 - an enabled watchdog keeps counting in every sleep mode
// R05 - fuse unprogrammed gives level 1 disabled; programmed gives level 2 always on
// R06 - level 1: enabling and period free; disabling needs key then one write
// R07 - level 2: reset enable reads one; period changes only inside key window
// R08 - key value 0xD8 written to change key register opens the window
// R09 - flag bit 7 set on interrupt expiry; cleared by vector or write one
// R10 - interrupt taken only with global enable, interrupt enable bit 6 and flag
// R11 - enable bits pick stopped, interrupt, reset, interrupt-then-reset; fuse forces reset
// R12 - interrupt-then-reset: first expiry flags, vector clears, second expiry resets
// R13 - software re-arms interrupt enable after each interrupt, not inside handler
// R14 - reset enable bit 3 forced while watchdog cause flag is set
// R15 - period codes 0 to 9 give 2048 doubling to 1048576 oscillator cycles
// R16 - period field msb at bit 5, low bits at bits 2:0
// R17 - reset expiry gives a one pclk cycle reset pulse
// R18 - cause flag set by watchdog reset, cleared by power-on or writing zero
// R19 - window closing unused blocks protected writes until a new key
// R20 - writes and expiries pass safely between register and counter logic
`timescale 1ns/1ps
module wdg_timer #(
   parameter int unsigned OSC_DIV = wdg_pkg::OSC_DIV,
   parameter int unsigned BASE_CYCLES = wdg_pkg::BASE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fuse pin, low when programmed
   input wire logic watchdog_lock_fuse_n,
   // device outputs
   output logic wdt_irq,
   output logic wdt_reset
);

   // fuse synchroniser
   logic fuse_s1;
   logic fuse_s2;
   logic fuse_s3;
   logic fuse_q;

   // state
   wdg_pkg::wdg_ctrl_t ctrl;
   wdg_pkg::wdg_ctrl_t next_ctrl;
   logic dog_reset_cause_flag;
   logic next_cause;
   logic gie;
   logic [2:0] key_cnt;
   logic [31:0] next_prdata;

   // apb decode
   wire [9:0] idx = paddr[wdg_pkg::ADDR_W-1:2];
   wire aligned = (paddr[1:0] == 2'b00);
   wire hit_ctrl = aligned && (idx == wdg_pkg::IDX_CTRL);
   wire hit_cause = aligned && (idx == wdg_pkg::IDX_CAUSE);
   wire hit_key = aligned && (idx == wdg_pkg::IDX_KEY);
   wire hit_cmd = aligned && (idx == wdg_pkg::IDX_CMD);
   wire hit_any = hit_ctrl || hit_cause || hit_key || hit_cmd;
   wire access = psel && penable;
   wire setup = psel && !penable;
   wire wr = access && pwrite;
   wire wr_ctrl = wr && hit_ctrl;
   wire wr_cause = wr && hit_cause;
   wire wr_key = wr && hit_key;
   wire wr_cmd = wr && hit_cmd;

   // command strobes
   wire restart = wr_cmd && pwdata[wdg_pkg::CMD_RESTART_BIT];
   wire vector_taken = wr_cmd && pwdata[wdg_pkg::CMD_VECTOR_BIT];

   // mode decode
   wire level2 = !fuse_q; // R05
   wire key_open = (key_cnt != 3'h0);
   wire wde_eff = level2 || ctrl.timeout_reset_enable || dog_reset_cause_flag; // R14
   wire enabled = wde_eff || ctrl.ie; // R11
   wire [3:0] period_code = {ctrl.wdp3, ctrl.wdp_lo}; // R16
   wire timeout;

   // write fields
   wire new_ie = pwdata[wdg_pkg::CTRL_IE_BIT];
   wire new_wde = pwdata[wdg_pkg::CTRL_WDE_BIT];
   wire new_wdp3 = pwdata[wdg_pkg::CTRL_WDP3_BIT];
   wire [2:0] new_wdp_lo = pwdata[2:0];
   wire flag_w1c = pwdata[wdg_pkg::CTRL_FLAG_BIT];

   // expiry action
   wdg_pkg::wdg_act_t act;
   assign act = !timeout ? wdg_pkg::WDG_ACT_NONE
              : level2 ? wdg_pkg::WDG_ACT_RESET // R11
              : (wde_eff && (!ctrl.ie || ctrl.flag)) ? wdg_pkg::WDG_ACT_RESET // R12
              : ctrl.ie ? wdg_pkg::WDG_ACT_IRQ
              : wdg_pkg::WDG_ACT_NONE;
   wire tmo_reset = (act == wdg_pkg::WDG_ACT_RESET); // R03
   wire tmo_irq = (act == wdg_pkg::WDG_ACT_IRQ);

   // counter keeps running whatever the cpu sleep state is
   wdg_prescaler #(
      .OSC_DIV(OSC_DIV),
      .BASE_CYCLES(BASE_CYCLES)
   ) u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .run(enabled), // R04
      .clear(restart || !enabled || wdt_reset), // R02
      .period_code(period_code),
      .timeout(timeout)
   );

   // fuse pin passes three flops, taken once the last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_s1 <= 1'b0;
         fuse_s2 <= 1'b0;
         fuse_s3 <= 1'b0;
      end else begin
         fuse_s1 <= watchdog_lock_fuse_n;
         fuse_s2 <= fuse_s1;
         fuse_s3 <= fuse_s2;
      end
   end

   // starts as programmed so the safe level holds until the pin settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_q <= 1'b0;
      end else if (fuse_s2 == fuse_s3) begin
         fuse_q <= fuse_s3; // R05
      end
   end

   // key window, any control write or the count running out closes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_cnt <= 3'h0;
      end else if (wdt_reset) begin
         key_cnt <= 3'h0;
      end else if (wr_key && (pwdata[7:0] == wdg_pkg::KEY_SIG)) begin
         key_cnt <= wdg_pkg::KEY_WINDOW; // R08
      end else if (wr_ctrl || !key_open) begin
         key_cnt <= 3'h0; // R19
      end else begin
         key_cnt <= key_cnt - 3'h1;
      end
   end

   // control register next value
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.ie = new_ie;
         if (flag_w1c) begin
            next_ctrl.flag = 1'b0; // R09
         end
         if (level2) begin
            if (key_open) begin
               next_ctrl.wdp3 = new_wdp3; // R07
               next_ctrl.wdp_lo = new_wdp_lo;
            end
         end else begin
            next_ctrl.wdp3 = new_wdp3; // R06
            next_ctrl.wdp_lo = new_wdp_lo;
            // clearing an enabled watchdog needs the open window
            next_ctrl.timeout_reset_enable = new_wde || (ctrl.timeout_reset_enable && !key_open); // R06
         end
      end
      if (vector_taken) begin
         next_ctrl.flag = 1'b0; // R09
         if (wde_eff) begin
            next_ctrl.ie = 1'b0; // R12
         end
      end
      // an expiry beats a clear in the same cycle
      if (tmo_irq) begin
         next_ctrl.flag = 1'b1; // R09
      end
      next_ctrl.rsv = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= wdg_pkg::CTRL_RESET;
      end else if (wdt_reset) begin
         ctrl <= wdg_pkg::CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // cause flag: write zero clears, watchdog reset sets and wins
   assign next_cause = wdt_reset ? 1'b1 // R18
                     : (wr_cause && !pwdata[wdg_pkg::CAUSE_DOG_BIT]) ? 1'b0
                     : dog_reset_cause_flag;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dog_reset_cause_flag <= 1'b0; // R18
      end else begin
         dog_reset_cause_flag <= next_cause;
      end
   end

   // global enable mirrors the cpu status bit, dropped by device reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie <= 1'b0;
      end else if (wdt_reset) begin
         gie <= 1'b0;
      end else if (wr_cmd) begin
         gie <= pwdata[wdg_pkg::CMD_GIE_BIT];
      end
   end

   // reset pulse one pclk cycle long
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset <= 1'b0;
      end else begin
         wdt_reset <= tmo_reset; // R17
      end
   end

   // interrupt request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_irq <= 1'b0;
      end else begin
         wdt_irq <= gie && next_ctrl.ie && next_ctrl.flag && !wdt_reset; // R10
      end
   end

   // read data, latched in the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl) begin
         next_prdata[7:0] = {ctrl.flag, ctrl.ie, ctrl.wdp3, 1'b0, wde_eff, ctrl.wdp_lo}; // R07
      end else if (hit_cause) begin
         next_prdata[wdg_pkg::CAUSE_DOG_BIT] = dog_reset_cause_flag;
      end else if (hit_cmd) begin
         next_prdata[wdg_pkg::CMD_GIE_BIT] = gie;
         next_prdata[wdg_pkg::CMD_RUN_BIT] = enabled;
         next_prdata[wdg_pkg::CMD_KEY_OPEN_BIT] = key_open;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // zero wait states; unmapped or unaligned answers with an error
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;

endmodule

// ### hdl/wdg_pkg.sv
// Purpose: shared constants and types for the watchdog timer block
// Assumes: 40 MHz pclk, APB word access, register index times four is the byte address
// Notes: reserved period codes behave as the longest period
package wdg_pkg;

   // clock and oscillator rates
   localparam int unsigned PCLK_FREQ_HZ = 40000000;
   localparam int unsigned OSC_FREQ_HZ = 128000;
   localparam int unsigned OSC_DIV = PCLK_FREQ_HZ / OSC_FREQ_HZ;

   // period select
   localparam int unsigned BASE_CYCLES = 2048;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
   localparam int unsigned CNT_W = 20;

   // protected change window
   localparam logic [7:0] KEY_SIG = 8'hD8;
   localparam logic [2:0] KEY_WINDOW = 3'h4;

   // apb address
   localparam int unsigned ADDR_W = 12;
   localparam logic [9:0] IDX_CTRL = 10'h031;
   localparam logic [9:0] IDX_CAUSE = 10'h03B;
   localparam logic [9:0] IDX_KEY = 10'h03C;
   localparam logic [9:0] IDX_CMD = 10'h03D;

   // field positions
   localparam int unsigned CTRL_FLAG_BIT = 7;
   localparam int unsigned CTRL_IE_BIT = 6;
   localparam int unsigned CTRL_WDP3_BIT = 5;
   localparam int unsigned CTRL_WDE_BIT = 3;
   localparam int unsigned CAUSE_DOG_BIT = 3;
   localparam int unsigned CMD_RESTART_BIT = 0;
   localparam int unsigned CMD_VECTOR_BIT = 1;
   localparam int unsigned CMD_GIE_BIT = 2;
   localparam int unsigned CMD_RUN_BIT = 3;
   localparam int unsigned CMD_KEY_OPEN_BIT = 4;

   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // control register layout, msb first
   typedef struct packed {
      logic flag;
      logic ie;
      logic wdp3;
      logic rsv;
      logic timeout_reset_enable;
      logic [2:0] wdp_lo;
   } wdg_ctrl_t;

   // action taken on an expiry
   typedef enum logic [1:0] {
      WDG_ACT_NONE = 2'b00,
      WDG_ACT_IRQ = 2'b01,
      WDG_ACT_RESET = 2'b10
   } wdg_act_t;

endpackage

// ### hdl/wdg_prescaler.sv
// Purpose: oscillator tick divider and period counter
// Assumes: run, clear and period_code come from pclk logic
// Notes: one pclk domain; the oscillator is a one-cycle enable
`timescale 1ns/1ps
module wdg_prescaler #(
   parameter int unsigned OSC_DIV = wdg_pkg::OSC_DIV,
   parameter int unsigned BASE_CYCLES = wdg_pkg::BASE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic clear,
   input wire logic [3:0] period_code,
   // event
   output logic timeout
);

   logic [15:0] div_cnt;
   logic [wdg_pkg::CNT_W-1:0] cnt;
   wire osc_tick;
   wire [3:0] code_c;
   wire [wdg_pkg::CNT_W-1:0] term;
   wire at_term;

   // free running tick stands in for the 128 kHz oscillator
   assign osc_tick = (div_cnt == 16'(OSC_DIV - 1)); // R01
   // reserved codes clamp to the longest period
   assign code_c = (period_code > wdg_pkg::PERIOD_MAX_CODE) ? wdg_pkg::PERIOD_MAX_CODE
                                                            : period_code;
   assign term = wdg_pkg::CNT_W'((BASE_CYCLES << code_c) - 1); // R15
   // a period shortened mid-count must not let the count run past its end
   assign at_term = (cnt >= term);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 16'h0000;
      end else if (osc_tick) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // no crossing needed: counter and register logic share pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         timeout <= 1'b0;
      end else if (clear) begin
         cnt <= '0; // R02
         timeout <= 1'b0;
      end else if (run && osc_tick) begin
         timeout <= at_term; // R20
         cnt <= at_term ? '0 : cnt + 1'b1;
      end else begin
         timeout <= 1'b0;
      end
   end

endmodule

// ### bench/wdg_timer_sva.sv
// Purpose: port-level property checks for the watchdog timer
// Assumes: single pclk domain; reduced OSC_DIV and BASE_CYCLES allowed
// Notes: bound to every wdg_timer instance
`timescale 1ns/1ps
module wdg_timer_chk #(
   parameter int unsigned OSC_DIV = wdg_pkg::OSC_DIV,
   parameter int unsigned BASE_CYCLES = wdg_pkg::BASE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic watchdog_lock_fuse_n,
   input wire logic wdt_irq,
   input wire logic wdt_reset
);
   localparam int MIN_GAP = (BASE_CYCLES - 1) * OSC_DIV;
   int gap;
   logic [2:0] fuse_low;
   wire acc = psel && penable;
   wire rd_ctrl = acc && !pwrite && paddr == 12'h0C4;
   wire restart = acc && pwrite && paddr == 12'h0F4 && pwdata[0];
   // tick phase makes the first expiry up to one divider early
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 0;
         fuse_low <= 3'h0;
      end else begin
         gap <= wdt_reset ? 0 : gap + 1;
         fuse_low <= watchdog_lock_fuse_n ? 3'h0 : fuse_low + {2'h0, fuse_low != 3'h5};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence no_reset8;
      !wdt_reset [*8];
   endsequence
   sequence no_irq3;
      !wdt_irq [*3];
   endsequence
   rst_pulse_a: assert property (wdt_reset |=> !wdt_reset)
      else $error("device reset pulse longer than one cycle");
   restart_hold_a: assert property (restart |-> ##3 no_reset8)
      else $error("device reset soon after restart");
   gap_min_a: assert property (wdt_reset |-> gap >= MIN_GAP)
      else $error("expiry shorter than shortest period");
   // read data is the setup-cycle copy, so compare with the setup-cycle request
   irq_flag_a: assert property (rd_ctrl && $past(wdt_irq) |-> prdata[7])
      else $error("interrupt without flag");
   ctrl_rsv_a: assert property (rd_ctrl |-> prdata[31:8] == 24'h0 && !prdata[4])
      else $error("unused control bits not zero");
   lvl2_wde_a: assert property (rd_ctrl && fuse_low == 3'h5 |-> prdata[3])
      else $error("reset enable reads zero at level two");
   irq_after_rst_a: assert property (wdt_reset |-> ##2 no_irq3)
      else $error("interrupt right after device reset");
   err_phase_a: assert property (pslverr |-> acc)
      else $error("error response outside access phase");
endmodule
bind wdg_timer wdg_timer_chk #(.OSC_DIV(OSC_DIV), .BASE_CYCLES(BASE_CYCLES)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .watchdog_lock_fuse_n(watchdog_lock_fuse_n), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset));

// ### bench/tb_wdg_timer.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: divider and base count cut to 4, so code 0 expires in 16 cycles
// Notes: period codes and restart spacing drawn from a fixed seed
`timescale 1ns/1ps
module tb_wdg_timer;
   localparam logic [11:0] CTRL = 12'h0C4, CAUSE = 12'h0EC, KEY = 12'h0F0, CMD = 12'h0F4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse_n = 1, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, wdt_irq, wdt_reset;
   logic [3:0] c;
   int fails = 0, comparisons = 0, n, resets = 0;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (wdt_reset === 1'b1) resets++;
   wdg_timer #(.OSC_DIV(4), .BASE_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .watchdog_lock_fuse_n(fuse_n), .wdt_irq(wdt_irq),
      .wdt_reset(wdt_reset));
   function int tout(input logic [3:0] code);
      return 16 << (code > 4'h9 ? 4'h9 : code);
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // no release here: the next call drops penable only, idle drops psel and penable
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
   endtask
   task idle(input int k);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (k) @(posedge pclk);
   endtask
   task rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   task wait_ev(input logic want_rst, input int lim);
      idle(1);
      n = 0;
      while ((want_rst ? wdt_reset : wdt_irq) !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task do_reset(input logic f);
      psel <= 1'b0;
      penable <= 1'b0;
      presetn <= 1'b0;
      fuse_n <= f;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   task wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      fails++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'h464a));
      do_reset(1'b1);
      rdc(CTRL, 8'h00);
      rdc(CAUSE, 8'h00);
      apb(1'b1, 12'h100, 8'hFF);
      chk(err, 1'b1);
      $display("reset values done");
      apb(1'b1, CMD, 8'h04);
      apb(1'b1, CTRL, 8'h40);
      wait_ev(0, 40);
      chk(n < 40, 1'b1);
      rdc(CTRL, 8'hC0);
      apb(1'b1, CTRL, 8'hC0);
      rdc(CTRL, 8'h40);
      wait_ev(0, 40);
      chk(n < 40, 1'b1);
      apb(1'b1, CMD, 8'h06);
      rdc(CTRL, 8'h40);
      apb(1'b1, CMD, 8'h00);
      wait_ev(0, 40);
      chk(n, 40);
      rdc(CTRL, 8'hC0);
      apb(1'b1, CTRL, 8'h80);
      apb(1'b1, CMD, 8'h04);
      for (int i = 0; i < 4; i++) begin
         c = (i == 0) ? 4'h9 : (i == 1) ? 4'($urandom % 6 + 10) : 4'($urandom % 4);
         apb(1'b1, CTRL, {2'b01, c[3], 2'b00, c[2:0]});
         apb(1'b1, CMD, 8'h05);
         wait_ev(0, 9000);
         chk(n + 8 >= tout(c) && n <= tout(c) + 4, 1'b1);
         apb(1'b1, CTRL, 8'h80);
      end
      $display("interrupt mode done");
      apb(1'b1, CTRL, 8'h08);
      repeat (6) begin
         apb(1'b1, CMD, 8'h01);
         idle($urandom % 6 + 1);
      end
      chk(resets, 0);
      wait_ev(1, 40);
      chk(n < 40, 1'b1);
      rdc(CAUSE, 8'h08);
      rdc(CTRL, 8'h08);
      apb(1'b1, KEY, 8'hD8);
      apb(1'b1, CTRL, 8'h00);
      rdc(CTRL, 8'h08);
      apb(1'b1, CMD, 8'h01);
      apb(1'b1, CAUSE, 8'h00);
      rdc(CAUSE, 8'h00);
      rdc(CTRL, 8'h00);
      $display("reset mode done");
      apb(1'b1, CTRL, 8'h0F);
      apb(1'b1, CTRL, 8'h07);
      rdc(CTRL, 8'h0F);
      apb(1'b1, KEY, 8'hD7);
      apb(1'b1, CTRL, 8'h07);
      rdc(CTRL, 8'h0F);
      apb(1'b1, KEY, 8'hD8);
      idle(3);
      apb(1'b1, CTRL, 8'h07);
      rdc(CTRL, 8'h0F);
      apb(1'b1, KEY, 8'hD8);
      idle(2);
      apb(1'b1, CTRL, 8'h07);
      rdc(CTRL, 8'h07);
      $display("disable sequence done");
      apb(1'b1, CMD, 8'h04);
      apb(1'b1, CTRL, 8'h48);
      wait_ev(0, 40);
      chk(n < 40, 1'b1);
      apb(1'b1, CMD, 8'h06);
      rdc(CTRL, 8'h08);
      apb(1'b1, CTRL, 8'h48);
      wait_ev(0, 40);
      chk(n < 40, 1'b1);
      wait_ev(1, 40);
      chk(n < 40, 1'b1);
      apb(1'b1, CMD, 8'h01);
      apb(1'b1, CAUSE, 8'h00);
      $display("interrupt then reset done");
      do_reset(1'b0);
      rdc(CTRL, 8'h08);
      apb(1'b1, CMD, 8'h01);
      apb(1'b1, CTRL, 8'h01);
      rdc(CTRL, 8'h08);
      apb(1'b1, KEY, 8'hD8);
      apb(1'b1, CTRL, 8'h01);
      rdc(CTRL, 8'h09);
      wait_ev(1, 80);
      chk(n < 80, 1'b1);
      $display("level two done");
      wrap_up;
   end
endmodule
